// File: core/lods_pkg.sv
// Constants shared by the LO divider-select block and its testbench.
// Assumes a 32-bit APB slave with byte addresses and 25 MHz pclk.
package lods_pkg;

	// Register byte offsets
	localparam logic [11:0] CTRL_OFS = 12'h000;
	localparam logic [11:0] DIV_OFS  = 12'h004;
	localparam logic [11:0] REF_OFS  = 12'h008;
	localparam logic [11:0] STAT_OFS = 12'h00C;
	localparam logic [11:0] RXW_OFS  = 12'h010;

	// Control register field positions
	localparam int unsigned CTRL_BAND_BIT  = 0;
	localparam int unsigned CTRL_RANGE_BIT = 1;
	localparam int unsigned CTRL_DOC_LSB   = 2;

	// Values after reset
	localparam logic        BAND_RST  = 1'b0;
	localparam logic        RANGE_RST = 1'b0;
	localparam logic [2:0]  DOC_RST   = 3'h0;
	localparam logic [15:0] DIV_RST   = 16'h0110;
	localparam logic [15:0] REF_RST   = 16'h0004;

	// Divisor limits per path
	localparam int unsigned DIV_W      = 16;
	localparam logic [15:0] SWL_MIN    = 16'h0110;
	localparam logic [15:0] SWL_MAX    = 16'hFFFF;
	localparam logic [15:0] DIR_MIN    = 16'h0004;
	localparam logic [15:0] DIR_MAX    = 16'h0FFF;
	localparam logic [15:0] DIR_MASK   = 16'h0FFF;

	// Serial control word layout
	localparam logic [4:0]  SER_WORD_LEN  = 5'h18;
	localparam logic [4:0]  SER_CNT_MAX   = 5'h1F;
	localparam int unsigned SER_DIV_LSB   = 0;
	localparam int unsigned SER_BAND_BIT  = 16;
	localparam int unsigned SER_RANGE_BIT = 17;
	localparam int unsigned SER_DOC_LSB   = 18;

	// Output content select codes
	localparam logic [2:0]  DOC_PHASE = 3'h0;
	localparam logic [2:0]  DOC_RANGE = 3'h1;
	localparam logic [2:0]  DOC_COUNT = 3'h2;
	localparam logic [2:0]  DOC_DIV   = 3'h3;

	// Synchroniser lanes
	localparam int unsigned IN_FM   = 0;
	localparam int unsigned IN_AM   = 1;
	localparam int unsigned IN_XTAL = 2;
	localparam int unsigned IN_CS   = 3;
	localparam int unsigned IN_STR  = 4;
	localparam int unsigned IN_DIN  = 5;
	localparam int unsigned SYNC_N  = 6;

	typedef enum logic [0:0] {SER_IDLE, SER_FRAME} lods_ser_t;

endpackage : lods_pkg

// File: core/lods_divider.sv
// Programmable down-counting divider: one output pulse per N input pulses.
// Assumes in_pulse is a one-cycle enable on pclk and divisor is static
// between reload pulses.
`timescale 1ns/1ps
module lods_divider #(
	parameter int unsigned W = 16
) (
	input  wire logic         pclk,
	input  wire logic         presetn,
	input  wire logic         in_pulse,
	input  wire logic         reload,
	input  wire logic [W-1:0] divisor,
	output logic              out_pulse,
	output logic [W-1:0]      count
);
	localparam logic [W-1:0] ONE = {{(W-1){1'b0}}, 1'b1};

	logic [W-1:0] next_count;
	logic         next_out_pulse;

	// Count down; reload the divisor at the end of each cycle
	always_comb
	begin
		next_count     = count;
		next_out_pulse = 1'b0;
		if (reload)
			next_count = divisor;
		else if (in_pulse)
		begin
			if (count <= ONE)
			begin
				next_count     = divisor; // RULE13
				next_out_pulse = 1'b1;    // RULE13
			end
			else
				next_count = count - ONE;
		end
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			count     <= '0;
			out_pulse <= 1'b0;
		end
		else
		begin
			count     <= next_count;
			out_pulse <= next_out_pulse;
		end
	end

	reload_wrap_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		(in_pulse && !reload && count <= ONE)
		|=> (out_pulse && count == $past(divisor)))
		else $error("divider did not pulse and reload at end of cycle");

	no_early_a: assert property (@(posedge pclk) disable iff (!presetn) // RULE13
		(!in_pulse || reload || count > ONE) |=> !out_pulse)
		else $error("divider pulsed before end of cycle");

endmodule : lods_divider

// File: core/lods_lo_divider_select.sv
// LO input and division path selection with serial and APB control.
// Assumes pins arrive asynchronous to pclk and far slower than it;
// the serial strobe is sampled, not used as a clock.
//
// Function
// RULE1 - Band bit 1 routes the FM input to the divider, AM ignored.
// RULE2 - FM input is halved before the swallow counter.
// RULE3 - FM divisor must be 272 to 65535; out of range is flagged.
// RULE4 - Band bit 0 routes the AM input to the divider instead.
// RULE5 - AM range bit 1: direct swallow count, divisor 272 to 65535.
// RULE6 - AM range bit 0: 12-bit direct divider, divisor 4 to 4095.
// RULE7 - Controller holds chip enable high for a whole transfer.
// RULE8 - Serial bits move only relative to the controller's strobe.
// RULE9 - Controller drives control data on the serial data input.
// RULE10 - Serial output content follows the three-bit select field.
// RULE11 - Reset sets control state with no controller action.
// RULE12 - Pump high if divided above reference, low if below, else off.
// RULE13 - Divider pulses once per cycle and reloads its divisor.
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/1ps
module lods_lo_divider_select #(
	parameter int unsigned PHASE_W = 8
) (
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic [11:0] paddr,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	input  wire logic        fm_local_osc_in,
	input  wire logic        am_local_osc_in,
	input  wire logic        crystal_in,
	output logic             crystal_out,
	input  wire logic        chip_enable,
	input  wire logic        serial_bit_strobe,
	input  wire logic        serial_data_in,
	output logic             serial_data_out,
	output logic             charge_pump_out,
	output logic             charge_pump_oe_n
);
	localparam logic signed [PHASE_W-1:0] ACC_MAX =
		{1'b0, {(PHASE_W-1){1'b1}}};
	localparam logic signed [PHASE_W-1:0] ACC_MIN =
		{1'b1, {(PHASE_W-1){1'b0}}};
	localparam logic signed [PHASE_W-1:0] ACC_ONE =
		{{(PHASE_W-1){1'b0}}, 1'b1};

	// Divisor out of range for the selected path
	function automatic logic lods_div_bad(input logic band,
		input logic range, input logic [15:0] div);
		if (band || range)
			lods_div_bad = (div < lods_pkg::SWL_MIN) ||
				(div > lods_pkg::SWL_MAX);
		else
			lods_div_bad = (div < lods_pkg::DIR_MIN) ||
				(div > lods_pkg::DIR_MAX);
	endfunction : lods_div_bad

	logic [lods_pkg::SYNC_N-1:0] raw_in;
	logic [lods_pkg::SYNC_N-1:0] sync1;
	logic [lods_pkg::SYNC_N-1:0] sync2;
	logic [lods_pkg::SYNC_N-1:0] sync3;
	logic [lods_pkg::SYNC_N-1:0] rise;
	logic [lods_pkg::SYNC_N-1:0] fall;

	assign raw_in = {serial_data_in, serial_bit_strobe, chip_enable,
		crystal_in, am_local_osc_in, fm_local_osc_in};

	// Two flops per pin, third flop only for edge finding
	for (genvar i = 0; i < lods_pkg::SYNC_N; i++)
	begin : g_sync
		always_ff @(posedge pclk or negedge presetn)
		begin
			if (!presetn)
			begin
				sync1[i] <= 1'b0;
				sync2[i] <= 1'b0;
				sync3[i] <= 1'b0;
			end
			else
			begin
				sync1[i] <= raw_in[i];
				sync2[i] <= sync1[i];
				sync3[i] <= sync2[i];
			end
		end
		assign rise[i] = sync2[i] & ~sync3[i];
		assign fall[i] = ~sync2[i] & sync3[i];
	end

	logic        fm_rise;
	logic        am_rise;
	logic        cs_rise;
	logic        cs_fall;
	logic        str_rise;
	logic        str_fall;
	assign fm_rise  = rise[lods_pkg::IN_FM];
	assign am_rise  = rise[lods_pkg::IN_AM];
	assign cs_rise  = rise[lods_pkg::IN_CS];
	assign cs_fall  = fall[lods_pkg::IN_CS];
	assign str_rise = rise[lods_pkg::IN_STR];
	assign str_fall = fall[lods_pkg::IN_STR];

	// Control and APB state
	logic        band_q, next_band;
	logic        range_q, next_range;
	logic [2:0]  doc_q, next_doc;
	logic [15:0] divisor_q, next_divisor;
	logic [15:0] refdiv_q, next_refdiv;
	logic [23:0] rx_word_q, next_rx_word;
	logic [31:0] next_prdata;
	logic        next_pready, next_pslverr;
	logic        div_reload, next_div_reload;
	logic        wr_en;
	logic        ser_load;

	// Serial state
	lods_pkg::lods_ser_t ser_state, next_ser_state;
	logic [4:0]  bit_cnt, next_bit_cnt;
	logic [23:0] rx_sr, next_rx_sr;
	logic [15:0] tx_sr, next_tx_sr;
	logic [15:0] tx_sel;
	logic        next_sdo;

	// Path and comparator state
	logic        presc, next_presc;
	logic        lo_pulse, next_lo_pulse;
	logic [15:0] eff_div;
	logic        div_out, ref_out;
	logic signed [PHASE_W-1:0] phase_acc, next_phase_acc;
	logic [15:0] pulse_cnt, next_pulse_cnt;
	logic        bad_div, next_bad_div;
	logic        next_pump, next_pump_oe_n, next_crystal_out;
	logic        pump_up, pump_dn;

	assign wr_en   = psel & penable & pready & pwrite;
	assign pump_up = charge_pump_out & ~charge_pump_oe_n;
	assign pump_dn = ~charge_pump_out & ~charge_pump_oe_n;

	// Reads prepared at setup so pready can come from a flop
	always_comb
	begin
		next_prdata   = 32'h0000_0000;
		next_pslverr  = 1'b0;
		next_pready   = psel & ~penable;
		next_band     = band_q;
		next_range    = range_q;
		next_doc      = doc_q;
		next_divisor  = divisor_q;
		next_refdiv   = refdiv_q;
		next_rx_word  = rx_word_q;
		case (paddr)
		lods_pkg::CTRL_OFS: next_prdata[4:0] = {doc_q, range_q, band_q};
		lods_pkg::DIV_OFS:  next_prdata[15:0] = divisor_q;
		lods_pkg::REF_OFS:  next_prdata[15:0] = refdiv_q;
		lods_pkg::STAT_OFS:
			next_prdata = {pulse_cnt, 13'h0000, bad_div, pump_dn, pump_up};
		lods_pkg::RXW_OFS:  next_prdata[23:0] = rx_word_q;
		default:            next_pslverr = psel & ~penable;
		endcase
		if (wr_en && paddr == lods_pkg::CTRL_OFS)
		begin
			next_band  = pwdata[lods_pkg::CTRL_BAND_BIT];
			next_range = pwdata[lods_pkg::CTRL_RANGE_BIT];
			next_doc   = pwdata[lods_pkg::CTRL_DOC_LSB +: 3];
		end
		if (wr_en && paddr == lods_pkg::DIV_OFS)
			next_divisor = pwdata[15:0];
		if (wr_en && paddr == lods_pkg::REF_OFS)
			next_refdiv = pwdata[15:0];
		// A serial frame ending in the same cycle wins: it is the newer data
		if (ser_load)
		begin
			next_divisor = rx_sr[lods_pkg::SER_DIV_LSB +: 16];
			next_band    = rx_sr[lods_pkg::SER_BAND_BIT];
			next_range   = rx_sr[lods_pkg::SER_RANGE_BIT];
			next_doc     = rx_sr[lods_pkg::SER_DOC_LSB +: 3];
			next_rx_word = rx_sr;
		end
		next_div_reload = (next_band != band_q) || (next_range != range_q)
			|| (next_divisor != divisor_q) || (next_refdiv != refdiv_q);
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			band_q     <= lods_pkg::BAND_RST;  // RULE11
			range_q    <= lods_pkg::RANGE_RST; // RULE11
			doc_q      <= lods_pkg::DOC_RST;   // RULE11
			divisor_q  <= lods_pkg::DIV_RST;   // RULE11
			refdiv_q   <= lods_pkg::REF_RST;
			rx_word_q  <= 24'h00_0000;
			prdata     <= 32'h0000_0000;
			pready     <= 1'b0;
			pslverr    <= 1'b0;
			div_reload <= 1'b0;
		end
		else
		begin
			band_q     <= next_band;
			range_q    <= next_range;
			doc_q      <= next_doc;
			divisor_q  <= next_divisor;
			refdiv_q   <= next_refdiv;
			rx_word_q  <= next_rx_word;
			prdata     <= next_prdata;
			pready     <= next_pready;
			pslverr    <= next_pslverr;
			div_reload <= next_div_reload;
		end
	end

	// Serial output word chosen by the content select field
	always_comb
	begin
		case (doc_q) // RULE10
		lods_pkg::DOC_PHASE: tx_sel = {14'h0000, pump_dn, pump_up};
		lods_pkg::DOC_RANGE: tx_sel = {15'h0000, bad_div};
		lods_pkg::DOC_COUNT: tx_sel = pulse_cnt;
		lods_pkg::DOC_DIV:   tx_sel = divisor_q;
		default:             tx_sel = 16'h0000;
		endcase
	end

	// Frame only counts when exactly one word arrived; others are dropped
	assign ser_load = (ser_state == lods_pkg::SER_FRAME) && cs_fall && // RULE7
		(bit_cnt == lods_pkg::SER_WORD_LEN);

	// Shift in on strobe rise, out on strobe fall, inside chip enable
	always_comb
	begin
		next_ser_state = ser_state;
		next_bit_cnt   = bit_cnt;
		next_rx_sr     = rx_sr;
		next_tx_sr     = tx_sr;
		next_sdo       = serial_data_out;
		case (ser_state)
		lods_pkg::SER_IDLE:
			if (cs_rise)
			begin
				next_ser_state = lods_pkg::SER_FRAME;
				next_bit_cnt   = 5'h00;
				next_tx_sr     = tx_sel; // RULE10
				next_sdo       = tx_sel[15];
			end
		lods_pkg::SER_FRAME:
			if (cs_fall)
			begin
				next_ser_state = lods_pkg::SER_IDLE; // RULE7
				next_sdo       = 1'b0;
			end
			else
			begin
				if (str_rise) // RULE8
				begin
					next_rx_sr = {rx_sr[22:0], sync2[lods_pkg::IN_DIN]}; // RULE9
					if (bit_cnt != lods_pkg::SER_CNT_MAX)
						next_bit_cnt = bit_cnt + 5'h01;
				end
				if (str_fall) // RULE8
				begin
					next_tx_sr = {tx_sr[14:0], 1'b0};
					next_sdo   = tx_sr[14];
				end
			end
		default:
			next_ser_state = lods_pkg::SER_IDLE;
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			ser_state       <= lods_pkg::SER_IDLE;
			bit_cnt         <= 5'h00;
			rx_sr           <= 24'h00_0000;
			tx_sr           <= 16'h0000;
			serial_data_out <= 1'b0;
		end
		else
		begin
			ser_state       <= next_ser_state;
			bit_cnt         <= next_bit_cnt;
			rx_sr           <= next_rx_sr;
			tx_sr           <= next_tx_sr;
			serial_data_out <= next_sdo;
		end
	end

	// Path select; the direct AM divider sees only 12 bits
	always_comb
	begin
		next_presc    = presc;
		next_lo_pulse = 1'b0;
		if (band_q)
		begin
			if (fm_rise)
			begin
				next_presc    = ~presc;         // RULE2
				next_lo_pulse = presc;          // RULE1 RULE2
			end
			eff_div = divisor_q;               // RULE2
		end
		else
		begin
			next_lo_pulse = am_rise;           // RULE4
			if (range_q)
				eff_div = divisor_q;           // RULE5
			else
				eff_div = divisor_q & lods_pkg::DIR_MASK; // RULE6
		end
		next_bad_div = lods_div_bad(band_q, range_q, divisor_q); // RULE3 RULE5 RULE6
	end

	lods_divider #(
		.W         (lods_pkg::DIV_W)
	) u_lo_div (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_pulse  (lo_pulse),
		.reload    (div_reload),
		.divisor   (eff_div),
		.out_pulse (div_out),
		.count     ()
	);

	// Reference from the crystal input, same leaf reused
	lods_divider #(
		.W         (lods_pkg::DIV_W)
	) u_ref_div (
		.pclk      (pclk),
		.presetn   (presetn),
		.in_pulse  (rise[lods_pkg::IN_XTAL]),
		.reload    (div_reload),
		.divisor   (refdiv_q),
		.out_pulse (ref_out),
		.count     ()
	);

	// Pulse balance as frequency detector; saturates to avoid wrap
	always_comb
	begin
		next_phase_acc = phase_acc;
		if (div_out && !ref_out && phase_acc != ACC_MAX)
			next_phase_acc = PHASE_W'(phase_acc + ACC_ONE);
		else if (ref_out && !div_out && phase_acc != ACC_MIN)
			next_phase_acc = PHASE_W'(phase_acc - ACC_ONE);
		next_pulse_cnt = div_out ? pulse_cnt + 16'h0001 : pulse_cnt;
		next_pump      = (phase_acc > 0);   // RULE12
		next_pump_oe_n = (phase_acc == 0);  // RULE12
		next_crystal_out      = ~sync2[lods_pkg::IN_XTAL];
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			presc            <= 1'b0;
			lo_pulse         <= 1'b0;
			phase_acc        <= '0;
			pulse_cnt        <= 16'h0000;
			bad_div          <= 1'b0;
			charge_pump_out  <= 1'b0;
			charge_pump_oe_n <= 1'b1;
			crystal_out      <= 1'b0;
		end
		else
		begin
			presc            <= next_presc;
			lo_pulse         <= next_lo_pulse;
			phase_acc        <= next_phase_acc;
			pulse_cnt        <= next_pulse_cnt;
			bad_div          <= next_bad_div;
			charge_pump_out  <= next_pump;
			charge_pump_oe_n <= next_pump_oe_n;
			crystal_out      <= next_crystal_out;
		end
	end

	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);

	sequence fm_edge_odd;
		band_q && fm_rise && presc;
	endsequence
	sequence fm_edge_even;
		band_q && fm_rise && !presc;
	endsequence

	fm_route_a: assert property ((band_q && !(fm_rise && presc)) // RULE1
		|=> !lo_pulse) else $error("LO pulse without FM edge in FM band");
	am_route_a: assert property ((!band_q && am_rise) |=> lo_pulse) // RULE4
		else $error("AM edge not routed in AM band");
	prescale_half_a: assert property ((fm_edge_even |=> presc && !lo_pulse) // RULE2
		and (fm_edge_odd |=> lo_pulse && !presc))
		else $error("FM prescaler not halving");
	fm_range_a: assert property ((band_q && divisor_q < lods_pkg::SWL_MIN) // RULE3
		|=> bad_div) else $error("low FM divisor not flagged");
	am_swallow_a: assert property ((!band_q && range_q && // RULE5
		divisor_q >= lods_pkg::SWL_MIN) |=> !bad_div && eff_div == divisor_q)
		else $error("AM swallow divisor wrong");
	am_direct_a: assert property ((!band_q && !range_q) |-> // RULE6
		(eff_div == (divisor_q & lods_pkg::DIR_MASK)) ##1
		(bad_div == ($past(divisor_q) > lods_pkg::DIR_MAX ||
		$past(divisor_q) < lods_pkg::DIR_MIN)))
		else $error("AM direct divisor wrong");
	serial_count_a: assert property ((ser_state == lods_pkg::SER_FRAME && // RULE8
		!cs_fall && str_rise && bit_cnt != lods_pkg::SER_CNT_MAX)
		|=> bit_cnt == $past(bit_cnt) + 5'h01)
		else $error("serial bit not counted on strobe");
	out_select_a: assert property ((ser_state == lods_pkg::SER_IDLE && // RULE10
		cs_rise) |=> tx_sr == $past(tx_sel))
		else $error("serial output word not loaded from select");
	reset_ctrl_a: assert property (@(posedge pclk) disable iff (1'b0) // RULE11
		!presetn |-> (band_q == lods_pkg::BAND_RST &&
		divisor_q == lods_pkg::DIV_RST && charge_pump_oe_n))
		else $error("control state not reset");
	pump_drive_a: assert property (((phase_acc > 0) |=> // RULE12
		(charge_pump_out && !charge_pump_oe_n)) and
		((phase_acc < 0) |=> (!charge_pump_out && !charge_pump_oe_n)) and
		((phase_acc == 0) |=> charge_pump_oe_n))
		else $error("charge pump state wrong");

endmodule : lods_lo_divider_select

// File: sim/lods_ctl_model.sv
// Serial controller model: drives chip enable, bit strobe and data in.
// Assumes one caller of xfer at a time and a 25 MHz pclk for pacing.
`timescale 1ns/1ps
module lods_ctl_model (
	input  wire logic        pclk,
	output logic             chip_enable,
	output logic             serial_bit_strobe,
	output logic             serial_data_in,
	input  wire logic        serial_data_out,
	output logic      [15:0] rx_word,
	output logic             rx_valid
);
	// Idle: strobe stands still, enable low
	initial
	begin
		chip_enable       = 1'b0;
		serial_bit_strobe = 1'b0;
		serial_data_in    = 1'b0;
		rx_word           = 16'h0000;
		rx_valid          = 1'b0;
	end

	// One frame, MSB first, strobe period 8 pclk; n below 24 is refused
	task automatic xfer(input logic [23:0] w, input int n);
		int i;
		chip_enable <= 1'b1;
		repeat (8) @(posedge pclk);
		for (i = 0; i < n; i++)
		begin
			serial_data_in <= w[23 - i];
			repeat (4) @(posedge pclk);
			serial_bit_strobe <= 1'b1;
			repeat (4) @(posedge pclk);
			// Read late in the high half, clear of the next change
			if (i < 16)
				rx_word[15 - i] <= serial_data_out;
			serial_bit_strobe <= 1'b0;
		end
		repeat (4) @(posedge pclk);
		chip_enable    <= 1'b0;
		// Released line shows the inverse, never a stale level
		serial_data_in <= ~serial_data_in;
		rx_valid       <= 1'b1;
		@(posedge pclk);
		rx_valid <= 1'b0;
		repeat (8) @(posedge pclk);
	endtask : xfer
endmodule : lods_ctl_model

// File: sim/test_lo_divider_select.sv
// Self-checking bench for the LO divider-select block.
// Assumes lods_pkg, the design files and lods_ctl_model come first.
`timescale 1ns/1ps
module test_lo_divider_select;
	typedef struct {string n; logic [32:0] e; logic [32:0] m;} lods_chk_t;
	localparam logic [32:0] ALL = 33'h1_FFFF_FFFF;
	logic        pclk, presetn, psel, penable, pwrite, fm, am, xt;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata;
	logic        pready, pslverr, ce, stb, sdi, sdo, pump, pump_oe_n, xo;
	logic        rx_valid;
	logic [15:0] rx_word, lo_pulses;
	int          miscompares, samples_checked;
	lods_chk_t   apb_q[$], ser_q[$];

	lods_lo_divider_select dut (
		.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
		.penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.fm_local_osc_in(fm), .am_local_osc_in(am), .crystal_in(xt),
		.crystal_out(xo), .chip_enable(ce), .serial_bit_strobe(stb),
		.serial_data_in(sdi), .serial_data_out(sdo),
		.charge_pump_out(pump), .charge_pump_oe_n(pump_oe_n)
	);
	lods_ctl_model u_ctl (
		.pclk(pclk), .chip_enable(ce), .serial_bit_strobe(stb),
		.serial_data_in(sdi), .serial_data_out(sdo),
		.rx_word(rx_word), .rx_valid(rx_valid)
	);

	// 25 MHz clock
	initial
	begin
		pclk = 1'b0;
		forever #20 pclk = ~pclk;
	end

	task automatic test_done;
		$display("checks %0d mismatches %0d", samples_checked, miscompares);
		if (miscompares == 0 && samples_checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : test_done

	task automatic cmp(input string n, input logic [32:0] e,
		input logic [32:0] g);
		samples_checked++;
		if (g !== e)
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, e, g);
		end
	endtask : cmp

	// Read results against the oldest note; error bit rides on top
	always @(posedge pclk)
	begin
		lods_chk_t c;
		if (psel && penable && !pwrite && pready === 1'b1)
		begin
			c = apb_q.pop_front();
			cmp(c.n, c.e & c.m, {pslverr, prdata} & c.m);
		end
		if (rx_valid)
		begin
			c = ser_q.pop_front();
			cmp(c.n, c.e & c.m, {17'h0_0000, rx_word} & c.m);
		end
	end

	// APB master; the wait for pready is bounded
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d);
		int k;
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= w;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		k = 0;
		do
		begin
			@(posedge pclk);
			k++;
		end
		while (pready !== 1'b1 && k < 16);
		if (k >= 16)
		begin
			miscompares++;
			test_done();
		end
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask : apb

	task automatic rd(input string n, input logic [11:0] a,
		input logic [32:0] e, input logic [32:0] m);
		apb_q.push_back('{n, e, m});
		apb(1'b0, a, 32'h0000_0000);
	endtask : rd

	// Edges on the masked pins: three cycles high, three low
	task automatic pulse(input logic [2:0] m, input int n);
		repeat (n)
		begin
			{xt, am, fm} <= m;
			repeat (3) @(posedge pclk);
			{xt, am, fm} <= 3'b000;
			repeat (3) @(posedge pclk);
		end
		repeat (8) @(posedge pclk);
	endtask : pulse

	task automatic do_reset;
		presetn <= 1'b0;
		repeat (12) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
	endtask : do_reset

	task automatic pin_chk(input logic oe_n, input logic hi);
		cmp("pump enable", {32'h0000_0000, oe_n}, {32'h0000_0000, pump_oe_n});
		if (!oe_n)
			cmp("pump level", {32'h0000_0000, hi}, {32'h0000_0000, pump});
	endtask : pin_chk

	// Frame plus the output word expected from the select before it
	task automatic snd(input logic [23:0] w, input int n, input logic [2:0] p,
		input logic [15:0] dv, input logic oor);
		logic [15:0] e, m;
		e = 16'h0000;
		m = 16'hFFFF;
		case (p)
			lods_pkg::DOC_PHASE: m = 16'hFFFC;
			lods_pkg::DOC_RANGE: e = {15'h0000, oor};
			lods_pkg::DOC_COUNT: e = lo_pulses;
			lods_pkg::DOC_DIV:   e = dv;
			default:             e = 16'h0000;
		endcase
		ser_q.push_back('{"serial out", {17'h0_0000, e}, {17'h0_0000, m}});
		u_ctl.xfer(w, n);
	endtask : snd

	// Watchdog: a hang ends in the same report
	initial
	begin
		repeat (90000) @(posedge pclk);
		miscompares++;
		test_done();
	end

	initial
	begin
		logic [15:0] rdv, dv;
		logic [2:0]  p;
		logic        bd, oor;
		int          d;
		// Reset starts high so its fall by NBA is seen as an edge
		{presetn, psel, penable, pwrite, fm, am, xt} = 7'h40;
		paddr = 12'h000;
		pwdata = 32'h0000_0000;
		miscompares = 0;
		samples_checked = 0;
		lo_pulses = 16'h0000;
		void'($urandom(95));
		do_reset();
		// Reset state, read-only status, unmapped place
		pin_chk(1'b1, 1'b0);
		rd("ctrl", lods_pkg::CTRL_OFS, 33'h0_0000_0000, ALL);
		rd("div", lods_pkg::DIV_OFS, 33'h0_0000_0110, ALL);
		rd("ref", lods_pkg::REF_OFS, 33'h0_0000_0004, ALL);
		// Reference divisor writable, upper bits reserved
		apb(1'b1, lods_pkg::REF_OFS, 32'hFFFF_0006);
		rd("ref", lods_pkg::REF_OFS, 33'h0_0000_0006, ALL);
		apb(1'b1, lods_pkg::STAT_OFS, 32'hFFFF_FFFF);
		rd("status", lods_pkg::STAT_OFS, 33'h0_0000_0000, ALL);
		rd("unmapped", 12'h014, 33'h1_0000_0000, ALL);
		$display("test reset done");
		// FM path: 1088 edges at 2 x 272 give two pulses; AM must not count
		apb(1'b1, lods_pkg::CTRL_OFS, 32'h0000_0001);
		pulse(3'b011, 1088);
		rd("fm count", lods_pkg::STAT_OFS, 33'h0_0002_0000,
			33'h0_FFFF_0004);
		apb(1'b1, lods_pkg::DIV_OFS, 32'h0000_010F);
		rd("fm range", lods_pkg::STAT_OFS, 33'h0_0000_0004, 33'h4);
		$display("test fm done");
		// AM swallow: 600 edges at 300 give two; FM ignored
		do_reset();
		apb(1'b1, lods_pkg::CTRL_OFS, 32'h0000_0002);
		apb(1'b1, lods_pkg::DIV_OFS, 32'h0000_012C);
		pulse(3'b011, 600);
		rd("am count", lods_pkg::STAT_OFS, 33'h0_0002_0000,
			33'h0_FFFF_0004);
		apb(1'b1, lods_pkg::DIV_OFS, 32'h0000_010F);
		rd("am range", lods_pkg::STAT_OFS, 33'h0_0000_0004, 33'h4);
		$display("test am swallow done");
		// AM direct: 0x1005 is out of range, 12 bits give five
		do_reset();
		apb(1'b1, lods_pkg::DIV_OFS, 32'h0000_1005);
		rd("dir range", lods_pkg::STAT_OFS, 33'h0_0000_0004, 33'h4);
		pulse(3'b011, 15);
		rd("dir count", lods_pkg::STAT_OFS, 33'h0_0003_0000,
			33'h0_FFFF_0000);
		apb(1'b1, lods_pkg::DIV_OFS, 32'h0000_0004);
		rd("dir range", lods_pkg::STAT_OFS, 33'h0_0000_0000, 33'h4);
		apb(1'b1, lods_pkg::DIV_OFS, 32'h0000_0003);
		rd("dir range", lods_pkg::STAT_OFS, 33'h0_0000_0004, 33'h4);
		$display("test am direct done");
		// Pump: three LO pulses lead, three references balance, two lag
		do_reset();
		apb(1'b1, lods_pkg::DIV_OFS, 32'h0000_0004);
		pulse(3'b010, 12);
		pin_chk(1'b0, 1'b1);
		pulse(3'b100, 12);
		pin_chk(1'b1, 1'b0);
		pulse(3'b100, 8);
		pin_chk(1'b0, 1'b0);
		lo_pulses = 16'h0003;
		// Oscillator output is the inverted crystal input
		xt <= 1'b1;
		repeat (6) @(posedge pclk);
		cmp("crystal out", {32'h0000_0000, ~xt}, {32'h0000_0000, xo});
		xt <= 1'b0;
		$display("test pump done");
		// Serial: random divisor, short frame refused, every select code
		rdv = 16'h0110 + 16'($urandom % 65264);
		bd = 1'($urandom);
		snd({3'h0, 3'h3, 1'b1, bd, rdv}, 24, 3'h0, 16'h0000, 1'b0);
		rd("ctrl", lods_pkg::CTRL_OFS, {28'h000_0000, 3'h3, 1'b1, bd}, ALL);
		rd("div", lods_pkg::DIV_OFS, {17'h0_0000, rdv}, ALL);
		rd("rxword", lods_pkg::RXW_OFS,
			{9'h000, 3'h0, 3'h3, 1'b1, bd, rdv}, ALL);
		snd({3'h0, 3'h1, 1'b1, bd, 16'h0064}, 23, 3'h3, rdv, 1'b0);
		rd("div", lods_pkg::DIV_OFS, {17'h0_0000, rdv}, ALL);
		p = 3'h3;
		dv = rdv;
		oor = 1'b0;
		for (d = 0; d <= 8; d++)
		begin
			snd({3'h0, 3'(d), 1'b1, bd, 16'h0064}, 24, p, dv, oor);
			p = 3'(d);
			dv = 16'h0064;
			oor = 1'b1;
		end
		$display("test serial done");
		test_done();
	end
endmodule : test_lo_divider_select
